// >>> hdl/pbc_regs.sv
`timescale 1ns/1ps
// phy basic control register and indexed read path
module pbc_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pbc_pkg::pbc_req_t req_i,
	input wire logic speed_strap_i,
	input wire logic an_complete_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	output logic hit_o,
	output pbc_pkg::pbc_ctl_t ctl_o
);
	import pbc_pkg::*;

	logic strap_s1_r;
	logic strap_s2_r;
	logic an_s1_r;
	logic an_s2_r;
	logic [15:0] bcr_r;
	logic [15:0] bcr_nxt;
	logic [2:0] srst_cnt_r;
	logic anrst_r;
	logic loaded_r;
	logic [15:0] rdata_r;
	logic rvalid_r;
	logic is_bcr;
	logic is_bsr;
	logic mapped;
	logic wr_bcr;
	logic start_srst;
	logic [15:0] bcr_rd;
	logic [15:0] bsr_rd;

	pbc_idx_dec u_dec (
		.idx_i(req_i.idx),
		.is_bcr_o(is_bcr),
		.is_bsr_o(is_bsr),
		.mapped_o(mapped)
	);

	// strap stages carry no reset, so they already hold the pin level when reset lets go
	always_ff @(posedge clk_i) begin
		strap_s1_r <= speed_strap_i;
		strap_s2_r <= strap_s1_r;
	end

	// completion flag comes from outside this clock; two stages
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			an_s1_r <= 1'b0;
			an_s2_r <= 1'b0;
		end else begin
			an_s1_r <= an_complete_i;
			an_s2_r <= an_s1_r;
		end
	end

	// only the bank's indexed port writes the control word, never a memory-mapped bus
	assign wr_bcr = req_i.wr & is_bcr;
	assign start_srst = wr_bcr & req_i.wdata[BIT_RST];

	// write merges only the writable bits, reserved bits stay zero
	assign bcr_nxt = (req_i.wdata & BCR_WMASK) | BCR_RESET;

	// read views: bit 15 and bit 9 show the self-clearing actions in progress
	assign bcr_rd = {(srst_cnt_r != 3'h0), bcr_r[14:10], anrst_r, bcr_r[8:0]} & 16'hFB80;
	assign bsr_rd = {10'h000, an_s2_r, 5'h00};

	// control word; hard reset clears everything, strap is captured after release
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bcr_r <= BCR_RESET;
			loaded_r <= 1'b0;
		end else if (!loaded_r) begin
			// strap is caught by a clocked load once the synchroniser has settled
			bcr_r <= BCR_RESET;
			bcr_r[BIT_SPEED] <= strap_s2_r;
			bcr_r[BIT_ANEN] <= strap_s2_r;
			loaded_r <= 1'b1;
		end else if (start_srst) begin
			// soft reset restores defaults; no field here is kept through it
			bcr_r <= BCR_RESET;
			bcr_r[BIT_SPEED] <= strap_s2_r;
			bcr_r[BIT_ANEN] <= strap_s2_r;
		end else if (srst_cnt_r != 3'h0) begin
			bcr_r <= bcr_r; // writes during soft reset are dropped, except one with bit 15 set, which restarts it
		end else if (wr_bcr) begin
			bcr_r <= bcr_nxt;
		end
	end

	// self-clearing soft reset counter and auto-negotiation restart pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			srst_cnt_r <= 3'h0;
			anrst_r <= 1'b0;
		end else begin
			if (start_srst)
				srst_cnt_r <= 3'(SRST_CYC);
			else if (srst_cnt_r != 3'h0)
				srst_cnt_r <= srst_cnt_r - 3'h1;
			// a restart written while soft reset runs is dropped like the rest of that write
			anrst_r <= wr_bcr & req_i.wdata[BIT_ANRST] & !start_srst & (srst_cnt_r == 3'h0);
		end
	end

	// read data registered one cycle after the request; unmapped reads zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= req_i.rd;
			if (req_i.rd)
				rdata_r <= is_bcr ? bcr_rd : (is_bsr ? bsr_rd : 16'h0000);
		end
	end

	assign rdata_o = rdata_r;
	assign rvalid_o = rvalid_r;
	assign hit_o = mapped;

	// forced speed and duplex only matter with negotiation off
	assign ctl_o.loopback = bcr_r[BIT_LOOP];
	assign ctl_o.speed_100 = bcr_r[BIT_ANEN] ? 1'b1 : bcr_r[BIT_SPEED];
	assign ctl_o.an_enable = bcr_r[BIT_ANEN];
	assign ctl_o.power_down = bcr_r[BIT_PDN];
	assign ctl_o.full_duplex = bcr_r[BIT_ANEN] ? 1'b1 : bcr_r[BIT_DUPLEX];
	assign ctl_o.col_test = bcr_r[BIT_COLT];
	assign ctl_o.an_restart = anrst_r;
	assign ctl_o.soft_reset = (srst_cnt_r != 3'h0);
endmodule

// >>> hdl/pbc_pkg.sv
// package for the phy basic control register bank
// Behaviour
// - PHY registers are reached only by index through the MAC management access path.
// - Index decoder selects 0,1,2,3,4,5,6,17,18,27,29,30,31 as documented registers.
// - Soft-reset-kept fields survive only the bit 15 reset; other resets clear them. The code keeps no field through the bit 15 reset.
// - Writing 1 to bit 15 starts soft reset; the bit clears itself.
// - Bit 14 set selects loopback, clear gives normal operation.
// - Bit 13 forces speed 100/10, ignored while auto-negotiation is enabled.
// - Bit 12 enables auto-negotiation, overriding forced speed and duplex.
// - Bit 11 set powers down; clearing returns to normal, then negotiation may run.
// - Auto-negotiation finishing after power-down sets basic status bit 5.
// - Writing 1 to bit 9 restarts auto-negotiation; the bit clears itself.
// - Bit 8 forces full or half duplex, ignored while auto-negotiation enabled.
// - Bit 7 enables the collision signal test.
// - Speed and auto-negotiation enable reset from the speed strap; others reset 0.
// - Basic status bit 5 reads 1 once auto-negotiation completed, else 0.
package pbc_pkg;
	localparam int IDX_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] IDX_BCR = 5'h00;
	localparam logic [4:0] IDX_BSR = 5'h01;
	localparam logic [4:0] IDX_ID1 = 5'h02;
	localparam logic [4:0] IDX_ID2 = 5'h03;
	localparam logic [4:0] IDX_ANADV = 5'h04;
	localparam logic [4:0] IDX_ANLPA = 5'h05;
	localparam logic [4:0] IDX_ANEXP = 5'h06;
	localparam logic [4:0] IDX_MCSR = 5'h11;
	localparam logic [4:0] IDX_SMODE = 5'h12;
	localparam logic [4:0] IDX_SCSI = 5'h1B;
	localparam logic [4:0] IDX_ISRC = 5'h1D;
	localparam logic [4:0] IDX_IMSK = 5'h1E;
	localparam logic [4:0] IDX_SCS = 5'h1F;
	localparam int BIT_RST = 15;
	localparam int BIT_LOOP = 14;
	localparam int BIT_SPEED = 13;
	localparam int BIT_ANEN = 12;
	localparam int BIT_PDN = 11;
	localparam int BIT_ANRST = 9;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_COLT = 7;
	localparam int BIT_ANDONE = 5;
	// writable storage bits: 14,13,12,11,8,7
	localparam logic [15:0] BCR_WMASK = 16'h7980;
	localparam logic [15:0] BCR_RESET = 16'h0000;
	// soft reset pulse length in clocks
	localparam int SRST_CYC = 4;
	// indexed access request from the management path
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] idx;
		logic [15:0] wdata;
	} pbc_req_t;
	// control outputs to the PHY core
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic an_enable;
		logic power_down;
		logic full_duplex;
		logic col_test;
		logic an_restart;
		logic soft_reset;
	} pbc_ctl_t;
endpackage

// >>> hdl/pbc_idx_dec.sv
`timescale 1ns/1ps
// index decoder for the phy register set
module pbc_idx_dec (
	input wire logic [4:0] idx_i,
	output logic is_bcr_o,
	output logic is_bsr_o,
	output logic mapped_o
);
	import pbc_pkg::*;
	// documented index map, everything else unmapped
	assign is_bcr_o = (idx_i == IDX_BCR);
	assign is_bsr_o = (idx_i == IDX_BSR);
	assign mapped_o = (idx_i <= IDX_ANEXP) || (idx_i == IDX_MCSR) || (idx_i == IDX_SMODE) ||
		(idx_i == IDX_SCSI) || (idx_i == IDX_ISRC) || (idx_i == IDX_IMSK) || (idx_i == IDX_SCS);
endmodule

// >>> tb/pbc_regs_checker.sv
`timescale 1ns/1ps
// checker for the phy basic control register bank
module pbc_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pbc_pkg::pbc_req_t req_i,
	input wire logic [15:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic hit_o,
	input wire pbc_pkg::pbc_ctl_t ctl_o
);
	import pbc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic s0, w0;
	// control writes made outside soft reset; w0 leaves out the reset bit
	assign s0 = req_i.wr && req_i.idx == IDX_BCR && !ctl_o.soft_reset;
	assign w0 = s0 && !req_i.wdata[15];
	property p_rv; req_i.rd |=> rvalid_o; endproperty
	a_rv: assert property (p_rv) else $error("no read answer");
	property p_hit; hit_o == (req_i.idx inside {[0:6], 17, 18, 27, 29, 30, 31}); endproperty
	a_hit: assert property (p_hit) else $error("index decode wrong");
	property p_unm; req_i.rd && !hit_o |=> rdata_o == 16'h0000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_srst; s0 && req_i.wdata[15] |=> ctl_o.soft_reset[*4] ##1 !ctl_o.soft_reset; endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
	property p_loop; w0 |=> ctl_o.loopback == $past(req_i.wdata[14]) && ctl_o.power_down == $past(req_i.wdata[11]); endproperty
	a_loop: assert property (p_loop) else $error("control bit not taken");
	property p_anr; w0 && req_i.wdata[9] |=> ctl_o.an_restart ##1 !ctl_o.an_restart; endproperty
	a_anr: assert property (p_anr) else $error("restart pulse wrong");
	// negotiation owns speed and duplex while enabled
	property p_fdx; ctl_o.an_enable |-> ctl_o.speed_100 && ctl_o.full_duplex; endproperty
	a_fdx: assert property (p_fdx) else $error("forced mode leaks");
	property p_rsv; req_i.rd && req_i.idx == IDX_BCR |=> rdata_o[10] == 1'h0 && rdata_o[6:0] == 7'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	c_srst: cover property ($fell(ctl_o.soft_reset));
	c_anr: cover property (ctl_o.an_restart);
	c_done: cover property (rvalid_o && rdata_o[5]);
endmodule
bind pbc_regs pbc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
	.hit_o(hit_o), .ctl_o(ctl_o));

// >>> tb/pbc_mgmt_model.sv
`timescale 1ns/1ps
// management path model issuing indexed requests
module pbc_mgmt_model (
	input wire logic clk_i,
	output pbc_pkg::pbc_req_t req_o
);
	import pbc_pkg::*;
	initial req_o = '0;
	// one request held over one rising edge; released fields show inverted junk
	task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
		@(negedge clk_i);
		req_o = '{wr: w, rd: !w, idx: i, wdata: d};
		@(negedge clk_i);
		req_o = '{wr: 1'h0, rd: 1'h0, idx: ~i, wdata: ~d};
	endtask
endmodule

// >>> tb/tb_phy_basic_control_regs.sv
`timescale 1ns/1ps
// self-checking bench for the phy basic control register bank
module tb_phy_basic_control_regs;
	import pbc_pkg::*;
	logic clk_i = 0, rst_i = 1, strap = 1, anc = 0, rv, hit, hit_q;
	logic [15:0] rdata;
	pbc_req_t req;
	pbc_ctl_t ctl;
	int err_total = 0, checks = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	pbc_mgmt_model mac (.clk_i(clk_i), .req_o(req));
	pbc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .speed_strap_i(strap), .an_complete_i(anc),
		.rdata_o(rdata), .rvalid_o(rv), .hit_o(hit), .ctl_o(ctl));
	// decode flag only stands while the request does; catch it at the taking edge
	always @(posedge clk_i) if (req.rd) hit_q <= hit;
	task complete_run;
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task rd(input logic [4:0] i, input logic [15:0] e);
		mac.acc(0, i, 16'h0000);
		chk("rvalid", 16'h0001, {15'h0000, rv});
		chk("rdata", e, rdata);
		chk("hit", {15'h0000, (i inside {[0:6], 17, 18, 27, 29, 30, 31})}, {15'h0000, hit_q});
	endtask
	// strap defaults, then soft reset resamples it and drops a write made meanwhile
	task t_reset;
		rd(IDX_BCR, 16'h3000);
		strap = 0;
		repeat (3) @(negedge clk_i);
		mac.acc(1, IDX_BCR, 16'h8000);
		chk("srst", 16'h0001, {15'h0000, ctl.soft_reset});
		mac.acc(1, IDX_BCR, 16'h4000);
		repeat (4) @(negedge clk_i);
		rd(IDX_BCR, 16'h0000);
	endtask
	// each writable bit alone, reserved bits with restart, then negotiation on
	task t_bits;
		int b[5] = '{14, 13, 11, 8, 7};
		logic [15:0] w;
		foreach (b[k]) begin
			w = 16'h0001 << b[k];
			mac.acc(1, IDX_BCR, w);
			rd(IDX_BCR, w);
			chk("ctl", {10'h000, w[14:11], w[8:7]}, {10'h000, ctl[7:2]});
		end
		mac.acc(1, IDX_BCR, 16'h067F);
		chk("anrst", 16'h0001, {15'h0000, ctl.an_restart});
		rd(IDX_BCR, 16'h0000);
		mac.acc(1, IDX_BCR, 16'h1000);
		chk("an", 16'h0068, {8'h00, ctl});
	endtask
	// completion flag passes through two sync stages to status bit 5
	task t_status;
		anc = 1;
		repeat (3) @(negedge clk_i);
		mac.acc(0, IDX_BSR, 16'h0000);
		chk("an_done", 16'h0020, rdata & 16'h0020);
		anc = 0;
		repeat (3) @(negedge clk_i);
		mac.acc(0, IDX_BSR, 16'h0000);
		chk("an_done", 16'h0000, rdata & 16'h0020);
	endtask
	initial begin
		repeat (16) @(negedge clk_i);
		rst_i = 0;
		t_reset();
		t_bits();
		t_status();
		for (int i = 2; i < 32; i++)
			rd(5'(i), 16'h0000);
		complete_run();
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end
endmodule
